// File: core/fbe_pkg.sv
// shared constants for the fill and bus error capture block
package fbe_pkg;
	// register word offsets
	localparam logic [7:0] FBE_OFS_CTRL = 8'h00;
	localparam logic [7:0] FBE_OFS_STATUS = 8'h04;
	localparam logic [7:0] FBE_OFS_BUS_ADDR = 8'h08;
	localparam logic [7:0] FBE_OFS_FILL_ADDR = 8'h0c;
	localparam logic [7:0] FBE_OFS_FILL_SYN = 8'h10;
	localparam logic [7:0] FBE_OFS_PROBE = 8'h14;
	localparam logic [7:0] FBE_OFS_UNLOCK = 8'h18;
	localparam logic [7:0] FBE_OFS_LOCKS = 8'h1c;
	// control register fields
	localparam int FBE_CTL_MC_ENABLE = 0;
	localparam int FBE_CTL_CORR_ENABLE = 1;
	localparam logic [1:0] FBE_CTL_RESET = 2'h0;
	// unlock register fields
	localparam int FBE_UNL_BUS = 0;
	localparam int FBE_UNL_FILL = 1;
	// status register fields
	localparam int FBE_ST_TPERR = 0;
	localparam int FBE_ST_TCPERR = 1;
	localparam int FBE_ST_HERR = 2;
	localparam int FBE_ST_CMD_LO = 4;
	localparam int FBE_ST_CMD_HI = 6;
	localparam int FBE_ST_BUS_FATAL = 7;
	localparam int FBE_ST_ERROR_FLAG_A = 8;
	localparam int FBE_ST_FILL_ISTREAM = 9;
	localparam int FBE_ST_FILL_CORRECTED = 10;
	localparam int FBE_ST_QW_LO = 11;
	localparam int FBE_ST_QW_HI = 12;
	localparam int FBE_ST_FILL_PAR = 13;
	localparam int FBE_ST_FILL_FATAL = 14;
	localparam logic [31:0] FBE_STATUS_RESET = 32'h0;
	// acknowledge codes on the command acknowledge lines
	localparam logic [2:0] FBE_ACK_IDLE = 3'h0;
	localparam logic [2:0] FBE_ACK_HARD_ERROR = 3'h3;
	// set indices
	localparam int FBE_SET_BUS = 0;
	localparam int FBE_SET_FILL = 1;
	localparam int FBE_NUM_SETS = 2;
endpackage : fbe_pkg

// File: core/fbe_probe_if.sv
// tag probe check results passed from the checker to the capture logic
`timescale 1ns/10ps
interface fbe_probe_if;
	logic done;
	logic tag_perr;
	logic ctl_perr;
	logic hit;
	modport checker_mp (output done, output tag_perr, output ctl_perr, output hit);
	modport user_mp (input done, input tag_perr, input ctl_perr, input hit);
endinterface : fbe_probe_if

// File: core/fbe_tag_check.sv
// external cache tag probe parity check and hit decision
`timescale 1ns/10ps
module fbe_tag_check #(
	parameter int TAG_W = 17,
	parameter int CTL_W = 3
) (
	// probe from the tag store
	input wire logic i_probe_done,
	input wire logic [TAG_W-1:0] i_probe_tag,
	input wire logic i_probe_tag_par,
	input wire logic [CTL_W-1:0] i_probe_ctl,
	input wire logic i_probe_ctl_par,
	input wire logic i_probe_match,
	input wire logic i_probe_valid,
	// results
	fbe_probe_if.checker_mp probe
);
	wire tag_bad;
	wire ctl_bad;
	assign tag_bad = ^{i_probe_tag, i_probe_tag_par};
	assign ctl_bad = ^{i_probe_ctl, i_probe_ctl_par};
	assign probe.done = i_probe_done;
	assign probe.tag_perr = i_probe_done & tag_bad;
	assign probe.ctl_perr = i_probe_done & ctl_bad;
	assign probe.hit = i_probe_done & i_probe_match & i_probe_valid & ~tag_bad & ~ctl_bad;
endmodule : fbe_tag_check

// File: core/fbe_lock_set.sv
// one lockable error register set with its lost-error flag
`timescale 1ns/10ps
module fbe_lock_set (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// events
	input wire logic i_err,
	input wire logic i_lost_kind,
	input wire logic i_unlock,
	// state
	output logic o_capture,
	output logic o_locked,
	output logic o_lost
);
	logic locked;
	logic lost;
	wire next_locked;
	wire next_lost;
	assign o_capture = i_err & ~locked;
	assign next_locked = o_capture | (locked & ~i_unlock);
	// lost error while locked; set beats clear
	assign next_lost = (i_err & i_lost_kind & locked) | (lost & ~i_unlock);
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			locked <= 1'b0;
			lost <= 1'b0;
		end else begin
			locked <= next_locked;
			lost <= next_lost;
		end
	end
	assign o_locked = locked;
	assign o_lost = lost;
endmodule : fbe_lock_set

// File: core/fbe_top.sv
// fill and bus error capture: error registers, locking, machine check
// Summary of operation
// - double-bit dstream fill data goes to the data cache unchanged, block valid
// - uncorrectable errors raise machine check only when enabled
// - double-bit data fill sets error_flag_a flag, istream and corrected clear
// - fill address keeps bits 33..2, quadword index in status
// - fill address bits 4..2 hold the failing load's address bits
// - fill syndrome register takes the failing quadword's syndrome
// - bus address and status 6..0 are unpredictable after a fill error
// - probe result kept on fill error if external cache enabled
// - tag parity errors detected at end of the tag probe
// - tag address parity error misses, sets flag, captures address
// - tag control parity error forces miss, sets flag, keeps probe
// - hard-error acknowledge sets flag, records command, captures address
// - two independent sets: bus status 7..0 and fill status 14..8
// - fill address, syndrome and upper status record fill errors apart
// - recording an error locks its set until software unlocks it
// - second error still posts interrupt or check, no overwrite
// - uncorrectable second error on a locked set sets its lost bit
// - bus lost bit set by probe parity or hard error while locked
// - fill lost bit set by any fill error while fill set locked
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module fbe_top
	import fbe_pkg::*;
#(
	parameter int TAG_W = 17,
	parameter int CTL_W = 3,
	parameter int SYN_W = 14,
	parameter int DATA_W = 64
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// primary cache fill
	input wire logic i_fill_valid,
	input wire logic [DATA_W-1:0] i_fill_data,
	input wire logic i_fill_istream,
	input wire logic i_fill_single_err,
	input wire logic i_fill_double_err,
	input wire logic i_fill_parity_err,
	input wire logic [33:2] i_fill_addr,
	input wire logic [1:0] i_fill_quadword_index,
	input wire logic [SYN_W-1:0] i_fill_syndrome,
	input wire logic i_fill_bc_en,
	// data cache write
	output logic o_dcache_wr,
	output logic [DATA_W-1:0] o_dcache_data,
	output logic [33:2] o_dcache_addr,
	output logic o_dcache_valid,
	// external cache tag probe
	input wire logic i_probe_done,
	input wire logic [TAG_W-1:0] i_probe_tag,
	input wire logic i_probe_tag_par,
	input wire logic [CTL_W-1:0] i_probe_ctl,
	input wire logic i_probe_ctl_par,
	input wire logic i_probe_match,
	input wire logic i_probe_valid,
	input wire logic [33:2] i_probe_addr,
	output logic o_bc_hit,
	output logic o_bc_miss,
	// system transaction
	input wire logic [2:0] i_request_command_lines,
	input wire logic [33:2] i_req_addr,
	input wire logic [2:0] i_command_acknowledge_lines,
	// exceptions
	output logic o_machine_check,
	output logic o_corrected_read_interrupt
);
	localparam int PROBE_W = TAG_W + CTL_W + 2;

	fbe_probe_if probe ();

	// control and captured state
	logic [1:0] memory_unit_control;
	logic [31:0] bus_interface_status;
	logic [33:2] bus_error_address;
	logic [33:2] fill_address;
	logic [SYN_W-1:0] fill_syndrome;
	logic [PROBE_W-1:0] ext_cache_probe_result;
	logic [PROBE_W-1:0] last_probe;
	logic [31:0] next_rdata;

	// set control
	logic [FBE_NUM_SETS-1:0] set_err;
	logic [FBE_NUM_SETS-1:0] set_lost_kind;
	logic [FBE_NUM_SETS-1:0] set_unlock;
	logic [FBE_NUM_SETS-1:0] set_capture;
	logic [FBE_NUM_SETS-1:0] set_locked;
	logic [FBE_NUM_SETS-1:0] set_lost;

	fbe_tag_check #(
		.TAG_W(TAG_W),
		.CTL_W(CTL_W)
	) u_tag_check (
		.i_probe_done(i_probe_done),
		.i_probe_tag(i_probe_tag),
		.i_probe_tag_par(i_probe_tag_par),
		.i_probe_ctl(i_probe_ctl),
		.i_probe_ctl_par(i_probe_ctl_par),
		.i_probe_match(i_probe_match),
		.i_probe_valid(i_probe_valid),
		.probe(probe)
	);

	// event decode
	wire fill_err;
	wire fill_fatal;
	wire fill_corrected;
	wire herr;
	wire probe_perr;
	wire bus_err;
	wire mchk_event;
	wire corr_event;

	assign fill_err = i_fill_valid & (i_fill_single_err | i_fill_double_err | i_fill_parity_err);
	assign fill_fatal = i_fill_valid & (i_fill_double_err | i_fill_parity_err);
	assign fill_corrected = fill_err & ~fill_fatal;
	assign herr = (i_command_acknowledge_lines == FBE_ACK_HARD_ERROR);
	assign probe_perr = probe.tag_perr | probe.ctl_perr;
	assign bus_err = herr | probe_perr;

	assign mchk_event = memory_unit_control[FBE_CTL_MC_ENABLE] & (fill_fatal | bus_err);
	assign corr_event = memory_unit_control[FBE_CTL_CORR_ENABLE] & fill_corrected;

	assign set_err[FBE_SET_BUS] = bus_err;
	assign set_err[FBE_SET_FILL] = fill_err;
	assign set_lost_kind[FBE_SET_BUS] = bus_err;
	assign set_lost_kind[FBE_SET_FILL] = fill_err;

	// register decode
	wire sel_ctrl;
	wire sel_status;
	wire sel_bus_addr;
	wire sel_fill_addr;
	wire sel_fill_syn;
	wire sel_probe;
	wire sel_unlock;
	wire sel_locks;

	assign sel_ctrl = (i_reg_addr == FBE_OFS_CTRL);
	assign sel_status = (i_reg_addr == FBE_OFS_STATUS);
	assign sel_bus_addr = (i_reg_addr == FBE_OFS_BUS_ADDR);
	assign sel_fill_addr = (i_reg_addr == FBE_OFS_FILL_ADDR);
	assign sel_fill_syn = (i_reg_addr == FBE_OFS_FILL_SYN);
	assign sel_probe = (i_reg_addr == FBE_OFS_PROBE);
	assign sel_unlock = (i_reg_addr == FBE_OFS_UNLOCK);
	assign sel_locks = (i_reg_addr == FBE_OFS_LOCKS);

	// read of the address register or explicit unlock
	assign set_unlock[FBE_SET_BUS] = (i_reg_rd & sel_bus_addr) |
		(i_reg_wr & sel_unlock & i_reg_wdata[FBE_UNL_BUS]);
	assign set_unlock[FBE_SET_FILL] = (i_reg_rd & sel_fill_addr) |
		(i_reg_wr & sel_unlock & i_reg_wdata[FBE_UNL_FILL]);

	genvar gs;
	generate
		for (gs = 0; gs < FBE_NUM_SETS; gs++) begin : g_set
			fbe_lock_set u_set (
				.i_sys_clk(i_sys_clk),
				.i_rst(i_rst),
				.i_err(set_err[gs]),
				.i_lost_kind(set_lost_kind[gs]),
				.i_unlock(set_unlock[gs]),
				.o_capture(set_capture[gs]),
				.o_locked(set_locked[gs]),
				.o_lost(set_lost[gs])
			);
		end
	endgenerate

	// probe result shared by both sets, held while either is locked
	wire tag_locked;
	wire probe_take_bus;
	wire probe_take_fill;
	wire [PROBE_W-1:0] probe_now;

	assign tag_locked = |set_locked;
	assign probe_now = {i_probe_tag, i_probe_tag_par, i_probe_ctl, i_probe_ctl_par};
	assign probe_take_bus = set_capture[FBE_SET_BUS] & probe_perr & ~tag_locked;
	assign probe_take_fill = set_capture[FBE_SET_FILL] & i_fill_bc_en & ~tag_locked;

	// status next value
	logic [31:0] next_status;
	always_comb begin
		next_status = bus_interface_status;
		if (set_capture[FBE_SET_BUS]) begin
			next_status[FBE_ST_TPERR] = probe.tag_perr;
			next_status[FBE_ST_TCPERR] = probe.ctl_perr;
			next_status[FBE_ST_HERR] = herr;
			next_status[FBE_ST_CMD_HI:FBE_ST_CMD_LO] = herr ? i_request_command_lines : 3'h0;
		end
		if (set_capture[FBE_SET_FILL]) begin
			next_status[FBE_ST_ERROR_FLAG_A] = i_fill_single_err | i_fill_double_err;
			next_status[FBE_ST_FILL_ISTREAM] = i_fill_istream;
			next_status[FBE_ST_FILL_CORRECTED] = fill_corrected;
			next_status[FBE_ST_FILL_PAR] = i_fill_parity_err;
			next_status[FBE_ST_QW_HI:FBE_ST_QW_LO] = i_fill_quadword_index;
		end
		next_status[FBE_ST_BUS_FATAL] = set_lost[FBE_SET_BUS];
		next_status[FBE_ST_FILL_FATAL] = set_lost[FBE_SET_FILL];
	end

	// registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			memory_unit_control <= FBE_CTL_RESET;
		end else if (i_reg_wr && sel_ctrl) begin
			memory_unit_control <= i_reg_wdata[1:0];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bus_interface_status <= FBE_STATUS_RESET;
		end else begin
			bus_interface_status <= next_status;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bus_error_address <= '0;
		end else if (set_capture[FBE_SET_BUS]) begin
			bus_error_address <= herr ? i_req_addr : i_probe_addr;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			fill_address <= '0;
			fill_syndrome <= '0;
		end else if (set_capture[FBE_SET_FILL]) begin
			// full address down to bit 2
			fill_address <= i_fill_addr;
			fill_syndrome <= i_fill_syndrome;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			last_probe <= '0;
		end else if (i_probe_done) begin
			last_probe <= probe_now;
		end
	end

	// fill errors take the probe of their own transaction, seen earlier
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_cache_probe_result <= '0;
		end else if (probe_take_fill) begin
			ext_cache_probe_result <= last_probe;
		end else if (probe_take_bus) begin
			ext_cache_probe_result <= probe_now;
		end
	end

	// data written as received, block valid
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dcache_wr <= 1'b0;
			o_dcache_valid <= 1'b0;
			o_dcache_data <= '0;
			o_dcache_addr <= '0;
		end else begin
			o_dcache_wr <= i_fill_valid & ~i_fill_istream;
			o_dcache_valid <= i_fill_valid & ~i_fill_istream;
			o_dcache_data <= i_fill_data;
			o_dcache_addr <= i_fill_addr;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bc_hit <= 1'b0;
			o_bc_miss <= 1'b0;
		end else begin
			o_bc_hit <= probe.hit;
			o_bc_miss <= probe.done & ~probe.hit;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_machine_check <= 1'b0;
			o_corrected_read_interrupt <= 1'b0;
		end else begin
			o_machine_check <= mchk_event;
			o_corrected_read_interrupt <= corr_event;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0;
		if (sel_ctrl) begin
			next_rdata[1:0] = memory_unit_control;
		end
		if (sel_status) begin
			next_rdata = bus_interface_status;
		end
		if (sel_bus_addr) begin
			next_rdata = bus_error_address;
		end
		if (sel_fill_addr) begin
			next_rdata = fill_address;
		end
		if (sel_fill_syn) begin
			next_rdata[SYN_W-1:0] = fill_syndrome;
		end
		if (sel_probe) begin
			next_rdata[PROBE_W-1:0] = ext_cache_probe_result;
		end
		if (sel_locks) begin
			next_rdata[FBE_NUM_SETS-1:0] = set_locked;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h0;
		end else if (i_reg_rd) begin
			o_reg_rdata <= next_rdata;
		end else begin
			o_reg_rdata <= 32'h0;
		end
	end
endmodule : fbe_top

// File: tb/fbe_top_monitor.sv
// concurrent checks on the error capture block's ports
`timescale 1ns/10ps
module fbe_top_monitor
	import fbe_pkg::*;
#(
	parameter int TAG_W = 17,
	parameter int CTL_W = 3,
	parameter int SYN_W = 14,
	parameter int DATA_W = 64
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// register writes
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	// fill
	input wire logic i_fill_valid,
	input wire logic [DATA_W-1:0] i_fill_data,
	input wire logic i_fill_istream,
	input wire logic i_fill_single_err,
	input wire logic i_fill_double_err,
	input wire logic i_fill_parity_err,
	input wire logic o_dcache_wr,
	input wire logic o_dcache_valid,
	input wire logic [DATA_W-1:0] o_dcache_data,
	// probe and transaction
	input wire logic i_probe_done,
	input wire logic [TAG_W-1:0] i_probe_tag,
	input wire logic i_probe_tag_par,
	input wire logic [CTL_W-1:0] i_probe_ctl,
	input wire logic i_probe_ctl_par,
	input wire logic i_probe_match,
	input wire logic i_probe_valid,
	input wire logic o_bc_hit,
	input wire logic o_bc_miss,
	input wire logic [2:0] i_command_acknowledge_lines,
	// exceptions
	input wire logic o_machine_check,
	input wire logic o_corrected_read_interrupt
);
	logic [1:0] ctl_en;
	logic mc_en, corr_en, perr, probe_bad, hard_ack, fill_unc;
	// mirror of the control register, loaded on the same edge as the design's
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_en <= FBE_CTL_RESET;
		end else if (i_reg_wr && i_reg_addr == FBE_OFS_CTRL) begin
			ctl_en <= i_reg_wdata[1:0];
		end
	end
	assign mc_en = ctl_en[FBE_CTL_MC_ENABLE];
	assign corr_en = ctl_en[FBE_CTL_CORR_ENABLE];
	assign perr = (^{i_probe_tag, i_probe_tag_par}) | (^{i_probe_ctl, i_probe_ctl_par});
	assign probe_bad = i_probe_done && perr;
	assign hard_ack = i_command_acknowledge_lines == FBE_ACK_HARD_ERROR;
	// parity errors on a fill are as fatal as double-bit ones
	assign fill_unc = i_fill_valid && (i_fill_double_err || i_fill_parity_err);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_dstream_fill;
		i_fill_valid && !i_fill_istream;
	endsequence
	sequence s_good_probe;
		i_probe_done && !perr && i_probe_match && i_probe_valid;
	endsequence
	chk_fill_dcache_wr: assert property (s_dstream_fill |=> o_dcache_wr && o_dcache_valid)
		else $error("dstream fill did not write the data cache");
	chk_fill_data_kept: assert property (s_dstream_fill |=> o_dcache_data == $past(i_fill_data))
		else $error("data cache did not get fill data as received");
	chk_bad_probe_miss: assert property (probe_bad |=> o_bc_miss && !o_bc_hit)
		else $error("probe parity error did not miss");
	chk_good_probe_hit: assert property (s_good_probe |=> o_bc_hit && !o_bc_miss)
		else $error("clean matching probe did not hit");
	chk_probe_quiet: assert property (!i_probe_done |=> !o_bc_hit && !o_bc_miss)
		else $error("hit or miss without a probe end");
	chk_mchk_gated: assert property (o_machine_check |-> $past(mc_en))
		else $error("machine check while disabled");
	chk_mchk_cause: assert property (o_machine_check |-> $past(hard_ack) || $past(fill_unc) || $past(probe_bad))
		else $error("machine check without an uncorrectable error");
	chk_hard_mchk: assert property (hard_ack && mc_en |=> o_machine_check)
		else $error("hard error acknowledge gave no machine check");
	chk_double_mchk: assert property (fill_unc && mc_en |=> o_machine_check)
		else $error("uncorrectable fill gave no machine check");
	chk_corr_post: assert property (i_fill_valid && i_fill_single_err && !fill_unc && corr_en
		|=> o_corrected_read_interrupt)
		else $error("single-bit fill gave no corrected read interrupt");
endmodule : fbe_top_monitor

bind fbe_top fbe_top_monitor #(.TAG_W(TAG_W), .CTL_W(CTL_W), .SYN_W(SYN_W), .DATA_W(DATA_W)) u_mon (
	.i_sys_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_fill_valid, .i_fill_data, .i_fill_istream,
	.i_fill_single_err, .i_fill_double_err, .i_fill_parity_err, .o_dcache_wr, .o_dcache_valid, .o_dcache_data,
	.i_probe_done,
	.i_probe_tag, .i_probe_tag_par, .i_probe_ctl, .i_probe_ctl_par, .i_probe_match, .i_probe_valid, .o_bc_hit,
	.o_bc_miss, .i_command_acknowledge_lines, .o_machine_check, .o_corrected_read_interrupt
);

// File: tb/fbe_far_side.sv
// stand-in for the tag store and the system bus acknowledge logic
`timescale 1ns/10ps
module fbe_far_side
	import fbe_pkg::*;
(
	// clock
	input wire logic i_sys_clk,
	// tag probe
	output logic o_probe_done,
	output logic [16:0] o_probe_tag,
	output logic o_probe_tag_par,
	output logic [2:0] o_probe_ctl,
	output logic o_probe_ctl_par,
	output logic o_probe_match,
	output logic o_probe_valid,
	output logic [33:2] o_probe_addr,
	// transaction
	output logic [2:0] o_req_cmd,
	output logic [33:2] o_req_addr,
	output logic [2:0] o_ack
);
	initial begin
		{o_probe_done, o_probe_tag, o_probe_tag_par, o_probe_ctl, o_probe_ctl_par} = '0;
		{o_probe_match, o_probe_valid, o_probe_addr, o_req_cmd, o_req_addr} = '0;
		o_ack = FBE_ACK_IDLE;
	end
	task automatic probe(input logic [33:2] a, input logic tbad, input logic cbad, input int gap);
		repeat (gap + 1) @(posedge i_sys_clk);
		o_probe_tag <= a[33:17];
		o_probe_tag_par <= ^a[33:17] ^ tbad;
		o_probe_ctl <= a[4:2];
		o_probe_ctl_par <= ^a[4:2] ^ cbad;
		{o_probe_match, o_probe_valid, o_probe_done} <= 3'h7;
		o_probe_addr <= a;
		@(posedge i_sys_clk);
		o_probe_done <= 1'b0;
		// lines mean nothing after done; invert so stale values cannot pass
		o_probe_tag <= ~a[33:17];
		o_probe_ctl <= ~a[4:2];
		o_probe_addr <= ~a;
		{o_probe_match, o_probe_valid} <= 2'h0;
	endtask : probe
	task automatic ack(input logic [2:0] cmd, input logic [33:2] a, input logic [2:0] code, input int gap);
		repeat (gap + 1) @(posedge i_sys_clk);
		o_req_cmd <= cmd;
		o_req_addr <= a;
		o_ack <= code;
		@(posedge i_sys_clk);
		o_ack <= FBE_ACK_IDLE;
		o_req_cmd <= ~cmd;
		o_req_addr <= ~a;
	endtask : ack
endmodule : fbe_far_side

// File: tb/test_fill_and_bus_error_capture.sv
// self-checking bench for the fill and bus error capture block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, exp, got); end end
module test_fill_and_bus_error_capture
	import fbe_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, fs;
	logic reg_wr, reg_rd, fill_valid, fill_ist, fill_sgl, fill_dbl, fill_par, pe, fill_bc_en, dc_wr, dc_valid;
	logic p_done, p_tpar, p_cpar, p_match, p_valid, bc_hit, bc_miss, mchk, corr_int, mc, cr;
	logic [63:0] fill_data, dc_data, d;
	logic [33:2] fill_addr, dc_addr, p_addr, r_addr, a;
	logic [1:0] fill_quadword_index, q;
	logic [13:0] fill_syn, s;
	logic [16:0] p_tag;
	logic [2:0] p_ctl, r_cmd, ack, c;
	int n_fail = 0;
	int samples_checked = 0;
	always #2.5 i_sys_clk = ~i_sys_clk;
	fbe_top dut (.i_sys_clk, .i_rst, .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_fill_valid(fill_valid), .i_fill_data(fill_data),
		.i_fill_istream(fill_ist), .i_fill_single_err(fill_sgl), .i_fill_double_err(fill_dbl),
		.i_fill_parity_err(fill_par), .i_fill_addr(fill_addr), .i_fill_quadword_index(fill_quadword_index), .i_fill_syndrome(fill_syn),
		.i_fill_bc_en(fill_bc_en), .o_dcache_wr(dc_wr), .o_dcache_data(dc_data), .o_dcache_addr(dc_addr),
		.o_dcache_valid(dc_valid), .i_probe_done(p_done), .i_probe_tag(p_tag), .i_probe_tag_par(p_tpar),
		.i_probe_ctl(p_ctl), .i_probe_ctl_par(p_cpar), .i_probe_match(p_match), .i_probe_valid(p_valid),
		.i_probe_addr(p_addr), .o_bc_hit(bc_hit), .o_bc_miss(bc_miss), .i_request_command_lines(r_cmd),
		.i_req_addr(r_addr), .i_command_acknowledge_lines(ack), .o_machine_check(mchk),
		.o_corrected_read_interrupt(corr_int));
	fbe_far_side far (.i_sys_clk, .o_probe_done(p_done), .o_probe_tag(p_tag), .o_probe_tag_par(p_tpar),
		.o_probe_ctl(p_ctl), .o_probe_ctl_par(p_cpar), .o_probe_match(p_match), .o_probe_valid(p_valid),
		.o_probe_addr(p_addr), .o_req_cmd(r_cmd), .o_req_addr(r_addr), .o_ack(ack));
	function automatic logic [31:0] fill_status(input logic ist, input logic sgl, input logic [1:0] qw);
		fill_status = '0;
		fill_status[FBE_ST_ERROR_FLAG_A] = 1'b1;
		fill_status[FBE_ST_FILL_ISTREAM] = ist;
		fill_status[FBE_ST_FILL_CORRECTED] = sgl;
		fill_status[FBE_ST_QW_HI:FBE_ST_QW_LO] = qw;
	endfunction : fill_status
	task automatic reg_write(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge i_sys_clk);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge i_sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] ad, output logic [31:0] v);
		@(posedge i_sys_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge i_sys_clk);
		reg_rd <= 1'b0;
		@(negedge i_sys_clk);
		v = reg_rdata;
	endtask : reg_read
	task automatic fill(input logic ist, input logic sgl, input logic dbl);
		@(posedge i_sys_clk);
		{fill_valid, fill_ist, fill_sgl, fill_dbl} <= {1'b1, ist, sgl, dbl};
		{fill_addr, fill_data, fill_quadword_index, fill_syn, fill_par} <= {a, d, q, s, pe};
		@(posedge i_sys_clk);
		fill_valid <= 1'b0;
		@(negedge i_sys_clk);
		mc = mchk;
		cr = corr_int;
		`CHK("dcache write", !ist, dc_wr)
		if (!ist) begin
			`CHK("dcache data", d, dc_data)
			`CHK("dcache addr", a, dc_addr)
		end
	endtask : fill
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	initial begin
		#100000;
		n_fail++;
		test_done();
	end
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, fill_valid, fill_ist, fill_sgl, fill_dbl} = '0;
		{fill_data, fill_addr, fill_quadword_index, fill_syn, fill_bc_en, fill_par, pe} = '0;
		void'($urandom(32'hd44ce8ae));
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		fill_bc_en <= 1'b1;
		reg_read(FBE_OFS_STATUS, rv);
		`CHK("status reset", FBE_STATUS_RESET, rv)
		reg_read(8'h20, rv);
		`CHK("unmapped read", 32'h0, rv)
		reg_write(FBE_OFS_CTRL, 32'h3);
		$display("test reset ends");
		a = $urandom;
		d = {$urandom, $urandom};
		q = 2'($urandom);
		s = 14'($urandom);
		fill(1'b0, 1'b0, 1'b1);
		`CHK("machine check", 1'b1, mc)
		reg_read(FBE_OFS_STATUS, rv);
		`CHK("fill status", fill_status(1'b0, 1'b0, q), rv)
		reg_read(FBE_OFS_LOCKS, rv);
		`CHK("locks", 32'h2, rv)
		{a, d, q} = {~a, ~d, ~q};
		fill(1'b0, 1'b1, 1'b0);
		`CHK("corrected while locked", 1'b1, cr)
		reg_read(FBE_OFS_STATUS, rv);
		`CHK("fill lost", fill_status(1'b0, 1'b0, ~q) | 32'h4000, rv)
		reg_read(FBE_OFS_FILL_SYN, rv);
		`CHK("syndrome", {18'h0, s}, rv)
		reg_read(FBE_OFS_FILL_ADDR, rv);
		`CHK("fill address", ~a, rv)
		reg_read(FBE_OFS_LOCKS, rv);
		`CHK("read unlocks", 32'h0, rv)
		reg_write(FBE_OFS_UNLOCK, 32'h2);
		fill(1'b1, 1'b1, 1'b0);
		`CHK("istream no mchk", 1'b0, mc)
		reg_read(FBE_OFS_STATUS, rv);
		`CHK("istream status", fill_status(1'b1, 1'b1, q), rv)
		reg_write(FBE_OFS_UNLOCK, 32'h2);
		// parity-only fill: fatal, no code error flags
		pe = 1'b1;
		fill(1'b0, 1'b0, 1'b0);
		`CHK("parity mchk", 1'b1, mc)
		reg_read(FBE_OFS_STATUS, rv);
		fs = 32'h2000 | (32'(q) << FBE_ST_QW_LO);
		`CHK("parity status", fs, rv)
		pe = 1'b0;
		reg_write(FBE_OFS_UNLOCK, 32'h2);
		$display("test fill errors ends");
		for (int k = 0; k < 3; k++) begin
			a = $urandom;
			far.probe(a, k == 1, k == 2, $urandom % 3);
			@(negedge i_sys_clk);
			`CHK("probe hit", k == 0, bc_hit)
			`CHK("probe mchk", k != 0, mchk)
			if (k != 0) begin
				reg_read(FBE_OFS_STATUS, rv);
				// fill bits stay from the last fill capture
				`CHK("tag parity flag", (32'h1 << (k - 1)) | fs, rv)
				reg_read(FBE_OFS_PROBE, rv);
				`CHK("probe result", {10'h0, a[33:17], ^a[33:17] ^ (k == 1), a[4:2], ^a[4:2] ^ (k == 2)}, rv)
				reg_read(FBE_OFS_BUS_ADDR, rv);
				`CHK("probe address", a, rv)
			end
		end
		$display("test probes ends");
		c = 3'($urandom);
		a = $urandom;
		far.ack(c, a, FBE_ACK_HARD_ERROR, 0);
		@(negedge i_sys_clk);
		`CHK("hard mchk", 1'b1, mchk)
		far.ack(~c, ~a, FBE_ACK_HARD_ERROR, 1);
		@(negedge i_sys_clk);
		`CHK("second mchk", 1'b1, mchk)
		reg_read(FBE_OFS_STATUS, rv);
		`CHK("hard status", fs | {24'h0, 1'b1, c, 4'h4}, rv)
		reg_read(FBE_OFS_BUS_ADDR, rv);
		`CHK("hard address", a, rv)
		reg_write(FBE_OFS_CTRL, 32'h0);
		far.ack(c, a, FBE_ACK_HARD_ERROR, 2);
		@(negedge i_sys_clk);
		`CHK("mchk disabled", 1'b0, mchk)
		reg_write(FBE_OFS_UNLOCK, 32'h1);
		reg_read(FBE_OFS_LOCKS, rv);
		`CHK("unlocked", 32'h0, rv)
		$display("test hard errors ends");
		test_done();
	end
endmodule : test_fill_and_bus_error_capture
